// File: rtl/ime_pkg.sv
// package: constants, register map and types of the two-wire master byte engine
package ime_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [4:0] OFS_XFER_BUFFER = 5'h00;
	localparam logic [4:0] OFS_CONTROL_2   = 5'h04;
	localparam logic [4:0] OFS_PORT_STATUS = 5'h08;
	localparam logic [4:0] OFS_ADDR_RELOAD = 5'h0C;
	localparam logic [4:0] OFS_PORT_CONFIG = 5'h10;
	// control_2 fields
	localparam int C2_STOP_EN  = 2;
	localparam int C2_RCV_EN   = 3;
	localparam int C2_ACK_EN   = 4;
	localparam int C2_ACK_DATA = 5;
	localparam int C2_ACK_STAT = 6;
	// port_status fields
	localparam int ST_BUF_FULL  = 0;
	localparam int ST_START_DET = 3;
	localparam int ST_STOP_DET  = 4;
	localparam int ST_WRITE_COLLISION_FLAG      = 8;
	localparam int ST_RX_OVF    = 9;
	localparam int ST_PORT_IRQ  = 10;
	localparam int ST_BUS_COLL  = 11;
	// port_config fields
	localparam int CF_ENABLE  = 0;
	localparam int CF_IRQ_ENA = 1;
	// reset values
	localparam logic [6:0] RST_ADDR_RELOAD = 7'h00;
	localparam logic [1:0] RST_PORT_CONFIG = 2'h0;
	// timing: instruction cycle and the clock it is built from
	localparam int CLK_NS        = 8;
	localparam int TCY_NS        = 32;
	localparam int TCY_CLKS      = (TCY_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_TCY_CLKS = (TCY_CLKS / 2 < 1) ? 1 : TCY_CLKS / 2;
	localparam int WRITE_COLLISION_FLAG_WIN_CLKS = 2 * TCY_CLKS;

	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_TX_LOW  = 4'b0001,
		S_TX_HIGH = 4'b0010,
		S_RX_LOW  = 4'b0011,
		S_RX_HIGH = 4'b0100,
		S_ACK_LOW = 4'b0101,
		S_ACK_HI  = 4'b0110,
		S_STOP_A  = 4'b0111,
		S_STOP_B  = 4'b1000,
		S_STOP_C  = 4'b1001,
		S_STOP_D  = 4'b1010,
		S_STOP_E  = 4'b1011
	} ime_state_t;

	// one bit per bus line
	typedef struct packed {
		logic scl;
		logic sda;
	} ime_line_t;
endpackage

// File: rtl/ime_transfer_engine.sv
// module: two-wire bus master byte engine with a classic wishbone register slave
//
// Overview of operation
// - buffer write sets buffer full and starts one byte transmission
// - data changes after scl falls; scl low one rollover, high one rollover
// - eighth falling edge clears buffer full and releases sda for acknowledge
// - ninth falling edge samples sda into ack status: low clears, high sets
// - after ninth clock set irq, stop counter, hold scl low, sda released
// - address phase shifts seven address bits then direction bit, msb first
// - buffer full is status bit 0; set by write, cleared after eight bits
// - write while shifting sets write collision; buffer updated only within 2 Tcy
// - receive enable only accepted while the engine is idle
// - reception: each rollover toggles scl, sda bits shift into shift_q
// - eighth received fall: clear enable, load buffer, set full and irq, idle
// - receive: buffer full set on load, cleared when software reads buffer while the engine is idle
// - overflow set when byte completes while buffer full still set
// - buffer write during receive, acknowledge or stop sets collision, no update
// - acknowledge sequence: drive ack data, low then high rollover, then idle
// - stop sequence: sda low, scl up, sda up, stop detected, then irq
// - port keeps working asleep and wakes processor on irq if enabled
// - reset or disable ends transfer and clears start and stop detected
// - released sda read low while scl high is a collision; go idle
// - collision in transmit: clear full, release lines, next write restarts
// - collision in a sequence clears its enable; stop on bus then sets irq
// - baud counter reloads from reload bits 6:0, counts down twice per Tcy
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ime_transfer_engine (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [4:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	input  wire ime_pkg::ime_line_t line_i,
	output ime_pkg::ime_line_t      line_o,
	output ime_pkg::ime_line_t      line_oe_o,
	output logic                    wake_o
);
	import ime_pkg::*;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// line synchronisers and bus condition detection
	ime_line_t  meta_q;
	ime_line_t  sync_q;
	ime_line_t  prev_q;
	always_ff @(posedge clk_i) begin
		meta_q <= line_i;
		sync_q <= meta_q;
		prev_q <= sync_q;
	end
	wire logic scl_s    = sync_q.scl;
	wire logic sda_s    = sync_q.sda;
	wire logic bus_stop = scl_s & prev_q.scl & sda_s & ~prev_q.sda;
	wire logic bus_strt = scl_s & prev_q.scl & ~sda_s & prev_q.sda;

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, write and read take effect on the ack edge
	logic        ack_q;
	logic [31:0] rdat_q;
	wire logic req      = wb_cyc_i & wb_stb_i;
	wire logic acc      = req & ack_q;
	wire logic wr       = acc & wb_we_i & wb_sel_i[0];
	wire logic buf_wr   = wr & (wb_adr_i == OFS_XFER_BUFFER);
	wire logic c2_wr    = wr & (wb_adr_i == OFS_CONTROL_2);
	wire logic st_wr    = acc & wb_we_i & (wb_adr_i == OFS_PORT_STATUS);
	wire logic rel_wr   = wr & (wb_adr_i == OFS_ADDR_RELOAD);
	wire logic cfg_wr   = wr & (wb_adr_i == OFS_PORT_CONFIG);
	wire logic buf_rd   = acc & ~wb_we_i & (wb_adr_i == OFS_XFER_BUFFER);
	// write-one-to-clear mask for the sticky flags, bits 11:8
	wire logic [3:0] w1c = (st_wr & wb_sel_i[1]) ? wb_dat_i[11:8] : 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// state
	ime_state_t state_q, state_d;
	logic [7:0] buf_q, shift_q;
	logic [3:0] bit_q;
	logic [6:0] reload_q, cnt_q;
	logic [1:0] cfg_q;
	logic       bf_q, write_collision_flag_q, ovf_q, irq_q, bcol_q, ack_stat_q, ack_data_q;
	logic       rcv_q, ack_seq_enable_q, pen_q, sdet_q, pdet_q, hold_q, mon_q;
	logic [$clog2(HALF_TCY_CLKS+1)-1:0] div_q;
	logic [$clog2(WRITE_COLLISION_FLAG_WIN_CLKS+1)-1:0] since_q;
	ime_line_t  oe_q;
	wire logic  en = cfg_q[CF_ENABLE];
	wire logic  idle = (state_q == S_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// baud counter: half-Tcy tick, reload on demand, rollover when zero meets a tick
	wire logic tick   = (div_q == '0);
	wire logic hi_ph  = (state_q == S_TX_HIGH) | (state_q == S_RX_HIGH) | (state_q == S_ACK_HI)
	                  | (state_q == S_STOP_C);
	// a released scl stalls the count until the line is really high (clock stretching)
	wire logic run    = ~idle & (state_q != S_STOP_A) & ~(hi_ph & ~scl_s);
	wire logic roll   = run & tick & (cnt_q == '0);
	wire logic tx_fall = (state_q == S_TX_HIGH) & roll;
	wire logic rx_fall = (state_q == S_RX_HIGH) & roll;
	wire logic exp_one = (state_q == S_TX_HIGH) & (bit_q < 4'd8) & shift_q[7];
	// released sda read low while scl high: another master won
	wire logic coll   = en & scl_s & ~sda_s & (exp_one | ((state_q == S_ACK_HI) & ack_data_q)
	                  | ((state_q == S_STOP_D) & roll));
	wire logic in_win = (since_q < WRITE_COLLISION_FLAG_WIN_CLKS[$bits(since_q)-1:0]);
	wire logic buf_ok = buf_wr & en & idle & ~rcv_q & ~ack_seq_enable_q & ~pen_q;
	wire logic buf_late = buf_wr & ~buf_ok;
	wire logic rx_done = rx_fall & (bit_q == 4'd7);

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (buf_ok)
					state_d = S_TX_LOW;
				else if (rcv_q)
					state_d = S_RX_LOW;
				else if (ack_seq_enable_q)
					state_d = S_ACK_LOW;
				else if (pen_q)
					state_d = S_STOP_A;
			end
			S_TX_LOW:  if (roll) state_d = S_TX_HIGH;
			S_TX_HIGH: if (roll) state_d = (bit_q == 4'd8) ? S_IDLE : S_TX_LOW;
			S_RX_LOW:  if (roll) state_d = S_RX_HIGH;
			S_RX_HIGH: if (roll) state_d = (bit_q == 4'd7) ? S_IDLE : S_RX_LOW;
			S_ACK_LOW: if (roll) state_d = S_ACK_HI;
			S_ACK_HI:  if (roll) state_d = S_IDLE;
			S_STOP_A:  if (~sda_s) state_d = S_STOP_B;
			S_STOP_B:  if (roll) state_d = S_STOP_C;
			S_STOP_C:  if (roll) state_d = S_STOP_D;
			S_STOP_D:  if (scl_s & sda_s) state_d = S_STOP_E;
			S_STOP_E:  if (roll) state_d = S_IDLE;
			default:   state_d = S_IDLE;
		endcase
		if (coll | ~en)
			state_d = S_IDLE;
	end
	wire logic enter = (state_d != state_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= '0;
			cnt_q <= '0;
		end else begin
			div_q <= tick ? $bits(div_q)'(HALF_TCY_CLKS - 1) : div_q - 1'b1;
			if (enter | (hi_ph & ~scl_s) | roll)
				cnt_q <= reload_q;
			else if (run & tick)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// engine registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			bit_q   <= '0;
			shift_q <= '0;
			since_q <= '0;
		end else begin
			state_q <= state_d;
			if (buf_ok)
				since_q <= '0;
			else if (in_win)
				since_q <= since_q + 1'b1;
			if (buf_ok | (buf_late & in_win & (state_q == S_TX_LOW) & (bit_q == '0)))
				shift_q <= wb_dat_i[7:0];
			else if (tx_fall)
				shift_q <= {shift_q[6:0], 1'b1};
			else if (rx_fall)
				shift_q <= {shift_q[6:0], sda_s};
			if (idle)
				bit_q <= '0;
			else if (tx_fall | rx_fall)
				bit_q <= bit_q + 1'b1;
		end
	end

	// open-drain line drive: enable high pulls the line low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_q   <= '0;
			hold_q <= 1'b0;
		end else if (coll | ~en) begin
			oe_q   <= '0;
			hold_q <= 1'b0;
		end else begin
			case (state_d)
				S_TX_LOW: begin
					oe_q.scl <= 1'b1;
					oe_q.sda <= (bit_q + {3'h0, tx_fall} < 4'd8) & ~(tx_fall ? shift_q[6] : shift_q[7]);
				end
				S_TX_HIGH, S_RX_HIGH, S_STOP_C: oe_q.scl <= 1'b0;
				S_RX_LOW:  oe_q <= '{scl: 1'b1, sda: 1'b0};
				S_ACK_LOW: oe_q <= '{scl: 1'b1, sda: ~ack_data_q};
				S_ACK_HI:  oe_q.scl <= 1'b0;
				S_STOP_A:  oe_q.sda <= 1'b1;
				S_STOP_D:  oe_q.sda <= 1'b0;
				S_IDLE: begin
					// after a byte or acknowledge the clock stays held low; a stop frees the bus
					oe_q.scl <= (state_q == S_STOP_E) ? 1'b0 : (hold_q | ~idle);
					oe_q.sda <= 1'b0;
				end
				default: oe_q <= oe_q;
			endcase
			hold_q <= ~(state_q == S_STOP_E) & (hold_q | (~idle & (state_d == S_IDLE)));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// buffer, flags and control bits; a hardware set always beats a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_q <= '0; bf_q <= 1'b0; write_collision_flag_q <= 1'b0; ovf_q <= 1'b0; irq_q <= 1'b0;
			bcol_q <= 1'b0; ack_stat_q <= 1'b0; ack_data_q <= 1'b0; rcv_q <= 1'b0;
			ack_seq_enable_q <= 1'b0; pen_q <= 1'b0; sdet_q <= 1'b0; pdet_q <= 1'b0; mon_q <= 1'b0;
			reload_q <= RST_ADDR_RELOAD;
			cfg_q    <= RST_PORT_CONFIG;
		end else begin
			if (rel_wr)
				reload_q <= wb_dat_i[6:0];
			if (cfg_wr)
				cfg_q <= wb_dat_i[1:0];
			if (buf_ok | (buf_late & in_win & (state_q == S_TX_LOW)))
				buf_q <= wb_dat_i[7:0];
			else if (rx_done)
				buf_q <= shift_q[6:0] == shift_q[6:0] ? {shift_q[6:0], sda_s} : buf_q;
			if (buf_ok | rx_done)
				bf_q <= 1'b1;
			else if ((tx_fall & (bit_q == 4'd7)) | (coll & (state_q == S_TX_HIGH)) | (buf_rd & ~hi_ph & idle))
				bf_q <= 1'b0;
			write_collision_flag_q <= (buf_wr & (~idle | rcv_q | ack_seq_enable_q | pen_q)) | (write_collision_flag_q & ~w1c[0]);
			ovf_q  <= (rx_done & bf_q) | (ovf_q & ~w1c[1]);
			irq_q  <= (tx_fall & (bit_q == 4'd8)) | rx_done | ((state_q == S_STOP_E) & roll)
			        | (mon_q & bus_stop) | (irq_q & ~w1c[2]);
			bcol_q <= coll | (bcol_q & ~w1c[3]);
			mon_q  <= coll | (mon_q & ~bus_stop);
			if (tx_fall & (bit_q == 4'd8))
				ack_stat_q <= sda_s;
			if (c2_wr) begin
				ack_data_q <= wb_dat_i[C2_ACK_DATA];
				if (idle & en & ~rcv_q & ~ack_seq_enable_q & ~pen_q) begin
					rcv_q   <= wb_dat_i[C2_RCV_EN];
					ack_seq_enable_q <= wb_dat_i[C2_ACK_EN];
					pen_q   <= wb_dat_i[C2_STOP_EN];
				end
			end
			if (rx_done | coll | ~en)
				rcv_q <= 1'b0;
			if (((state_q == S_ACK_HI) & roll) | coll | ~en)
				ack_seq_enable_q <= 1'b0;
			if (((state_q == S_STOP_E) & roll) | coll | ~en)
				pen_q <= 1'b0;
			if (~en) begin
				sdet_q <= 1'b0;
				pdet_q <= 1'b0;
			end else if (bus_stop | ((state_q == S_STOP_D) & scl_s & sda_s)) begin
				pdet_q <= 1'b1;
				sdet_q <= 1'b0;
			end else if (bus_strt) begin
				sdet_q <= 1'b1;
				pdet_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux and registered outputs
	logic [31:0] rmux;
	always_comb begin
		case (wb_adr_i)
			OFS_XFER_BUFFER: rmux = {24'h00_0000, buf_q};
			OFS_CONTROL_2:   rmux = {25'h000_0000, ack_stat_q, ack_data_q, ack_seq_enable_q, rcv_q, pen_q, 2'h0};
			OFS_PORT_STATUS: rmux = {20'h0_0000, bcol_q, irq_q, ovf_q, write_collision_flag_q, 3'h0, pdet_q, sdet_q, 2'h0, bf_q};
			OFS_ADDR_RELOAD: rmux = {25'h000_0000, reload_q};
			OFS_PORT_CONFIG: rmux = {30'h0000_0000, cfg_q};
			default:         rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= '0;
			wake_o <= 1'b0;
		end else begin
			ack_q  <= req & ~ack_q;
			rdat_q <= (req & ~ack_q) ? rmux : rdat_q;
			wake_o <= irq_q & cfg_q[CF_IRQ_ENA];
		end
	end
	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = rdat_q;
	assign line_oe_o = oe_q;
	assign line_o    = '0;

	////////////////////////////////////////////////////////////////////////////
	// checks
	chk_bf_on_write: assert property (buf_ok |=> bf_q && state_q == S_TX_LOW)
		else $error("buffer write did not start a transmission");
	chk_scl_high_tx: assert property ((state_q == S_TX_HIGH) |-> !oe_q.scl)
		else $error("scl held low during the high phase");
	chk_bf_eighth: assert property (tx_fall && bit_q == 4'd7 && !coll |=> !bf_q && !oe_q.sda)
		else $error("buffer full or sda not released after eighth bit");
	chk_ack_status: assert property (tx_fall && bit_q == 4'd8 && !coll |=> ack_stat_q == $past(sda_s))
		else $error("ack status does not follow sampled sda");
	chk_ninth_hold: assert property (tx_fall && bit_q == 4'd8 && en |=> irq_q && idle ##1 oe_q.scl && !oe_q.sda)
		else $error("no irq or wrong line hold after ninth clock");
	chk_write_collision_flag_busy: assert property (buf_wr && !idle |=> write_collision_flag_q)
		else $error("write during activity did not set collision flag");
	chk_rcv_ignore: assert property (c2_wr && !idle && !rcv_q |=> !rcv_q)
		else $error("receive enable accepted while busy");
	chk_rx_done: assert property (rx_done && en |=> bf_q && irq_q && !rcv_q && idle)
		else $error("receive completion incomplete");
	chk_rx_overflow: assert property (rx_done && bf_q |=> ovf_q)
		else $error("overflow not flagged");
	chk_coll_idle: assert property (coll |=> bcol_q && idle && oe_q == '0)
		else $error("collision did not release the bus");
	chk_stop_end: assert property ((state_q == S_STOP_E) && roll && en |=> !pen_q && irq_q && pdet_q)
		else $error("stop sequence did not complete");
endmodule
`default_nettype wire

// File: tb/ime_slave_model.sv
// file: behavioural two-wire slave standing on the engine's far side
`timescale 1ns/10ps
`default_nettype none
module ime_slave_model (
	input  wire logic       clk_i,
	input  wire logic       restart_i,
	input  wire logic       rx_mode_i,
	input  wire logic       give_ack_i,
	input  wire logic [7:0] rx_byte_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic      [7:0] got_o,
	output logic            sda_oe_o
);
	logic       scl_q;
	logic       ack_q;
	logic [3:0] rise_q;
	logic [3:0] fall_q;
	always_ff @(posedge clk_i) begin
		scl_q <= scl_i;
		if (restart_i) begin
			rise_q <= 4'h0;
			fall_q <= 4'h0;
			ack_q  <= 1'b0;
		end else if (!scl_q && scl_i && rise_q < 4'h9) begin
			rise_q <= rise_q + 4'h1;
			if (!rx_mode_i && rise_q < 4'h8) got_o <= {got_o[6:0], sda_i};
		end else if (scl_q && !scl_i) begin
			fall_q <= fall_q + 4'h1;
			// only a receiving slave answers; a sending slave must leave sda free after its byte
			ack_q  <= give_ack_i && !rx_mode_i && rise_q == 4'h8;
		end
	end
	// bits are only changed while scl is low, so the master never sees a false stop
	assign sda_oe_o = rx_mode_i ? (fall_q < 4'h8 && !rx_byte_i[3'd7 - fall_q[2:0]]) : ack_q;
endmodule
`default_nettype wire

// File: tb/ime_transfer_engine_test.sv
// file: self-checking bench of the two-wire master byte engine
`timescale 1ns/10ps
`default_nettype none
module ime_transfer_engine_test;
	import ime_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, coll = 1'b0, rst_s = 1'b1, rxm = 1'b0, gack = 1'b1;
	logic [4:0]  adr = 5'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, rd, dat_o;
	logic        ack, wake, scl_w, sda_w, s_oe;
	logic [7:0]  rxb = 8'h00, got, b;
	logic [1:0]  k;
	ime_line_t   li, lo, loe;
	int          n_errors = 0, compares = 0, cycles = 0, seed = 4400;
	int          exp_q[$];

	always #4 clk_i = ~clk_i;
	assign scl_w = ~loe.scl;
	assign sda_w = ~(loe.sda | s_oe | coll);
	assign li = '{scl: scl_w, sda: sda_w};

	ime_transfer_engine ime_transfer_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.line_i(li), .line_o(lo), .line_oe_o(loe), .wake_o(wake));
	ime_slave_model ime_slave_model_inst (.clk_i(clk_i), .restart_i(rst_s), .rx_mode_i(rxm), .give_ack_i(gack),
		.rx_byte_i(rxb), .scl_i(scl_w), .sda_i(sda_w), .got_o(got), .sda_oe_o(s_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors = n_errors + 1;
			wrap_up;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// classic cycle: request held until ack is sampled, then dropped for a cycle
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic poll(input int n);
		rd = 32'h0000_0000;
		for (int i = 0; i < 300 && rd[n] !== 1'b1; i++) bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
	endtask

	task automatic clr;
		bus(1'b1, OFS_PORT_STATUS, 32'h0000_0f00, 4'b0010);
	endtask

	task automatic restart(input logic m);
		rst_s <= 1'b1;
		rxm   <= m;
		@(posedge clk_i);
		rst_s <= 1'b0;
	endtask

	task automatic tx(input logic [7:0] v, input logic a, input int late);
		gack <= a;
		restart(1'b0);
		exp_q.push_back(v);
		bus(1'b1, OFS_XFER_BUFFER, {24'h00_0000, v}, 4'h1);
		bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
		chk("buffer_full", 1, rd[ST_BUF_FULL]);
		chk("write_collision_flag_clear", 0, rd[ST_WRITE_COLLISION_FLAG]);
		chk("line_drive", 0, lo);
		if (late > 0) begin
			repeat (late) @(posedge clk_i);
			bus(1'b1, OFS_XFER_BUFFER, 32'h0000_005a, 4'h1);
			bus(1'b1, OFS_CONTROL_2, 32'h0000_0008, 4'h1);
			bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
			chk("write_collision_flag", 1, rd[ST_WRITE_COLLISION_FLAG]);
		end
		poll(ST_PORT_IRQ);
		chk("irq", 1, rd[ST_PORT_IRQ]);
		chk("buffer_full_end", 0, rd[ST_BUF_FULL]);
		chk("line_oe", 2'b10, loe);
		chk("tx_byte", exp_q.pop_front(), got);
		chk("wake", 1, wake);
		bus(1'b0, OFS_CONTROL_2, 32'h0000_0000, 4'hf);
		chk("ack_status", !a, rd[C2_ACK_STAT]);
		chk("rcv_busy", 0, rd[C2_RCV_EN]);
		clr;
		$display("tx %h done", v);
	endtask

	task automatic rx(input logic [7:0] v, input logic rdbuf, input logic ovf);
		rxb <= v;
		restart(1'b1);
		bus(1'b1, OFS_CONTROL_2, 32'h0000_0008, 4'h1);
		bus(1'b1, OFS_XFER_BUFFER, 32'h0000_0055, 4'h1);
		poll(ST_PORT_IRQ);
		chk("write_collision_flag_rx", 1, rd[ST_WRITE_COLLISION_FLAG]);
		chk("buffer_full_rx", 1, rd[ST_BUF_FULL]);
		chk("overflow", ovf, rd[ST_RX_OVF]);
		chk("line_oe_rx", 2'b10, loe);
		bus(1'b0, OFS_CONTROL_2, 32'h0000_0000, 4'hf);
		chk("rcv_clear", 0, rd[C2_RCV_EN]);
		if (rdbuf) begin
			bus(1'b0, OFS_XFER_BUFFER, 32'h0000_0000, 4'hf);
			if (!ovf) chk("rx_byte", v, rd);
			bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
			chk("buffer_full_read", 0, rd[ST_BUF_FULL]);
		end
		clr;
		restart(1'b0);
		$display("rx %h done", v);
	endtask

	task automatic ack_seq(input logic d);
		k = 2'b10;
		bus(1'b1, OFS_CONTROL_2, {26'h000_0000, d, 5'h10}, 4'h1);
		for (int i = 0; i < 300 && k == 2'b10; i++) begin
			@(posedge clk_i);
			if (loe.scl === 1'b0) k = {1'b0, loe.sda};
		end
		chk("ack_sda", !d, k);
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, OFS_CONTROL_2, 32'h0000_0000, 4'hf);
			if (rd[C2_ACK_EN] === 1'b0) break;
		end
		chk("ack_en_clear", 0, rd[C2_ACK_EN]);
		chk("ack_scl_low", 1, loe.scl);
		$display("ack %b done", d);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 24; a += 4) begin
			bus(1'b0, 5'(a), 32'h0000_0000, 4'hf);
			chk("reset_reg", 0, rd);
		end
		bus(1'b1, OFS_PORT_CONFIG, 32'h0000_0003, 4'h1);
		bus(1'b1, OFS_ADDR_RELOAD, 32'h0000_0002, 4'h1);
		tx(8'ha5, 1'b1, 0);
		tx(8'h6e, 1'b0, 0);
		tx(8'hc3, 1'b1, 30);
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			tx(b, b[0], 0);
		end
		rx(8'h96, 1'b1, 1'b0);
		rx(8'h3b, 1'b0, 1'b0);
		rx(8'he1, 1'b1, 1'b1);
		ack_seq(1'b0);
		ack_seq(1'b1);
		bus(1'b1, OFS_CONTROL_2, 32'h0000_0004, 4'h1);
		poll(ST_PORT_IRQ);
		chk("stop_det", 1, rd[ST_STOP_DET]);
		chk("stop_lines", 0, loe);
		bus(1'b0, OFS_CONTROL_2, 32'h0000_0000, 4'hf);
		chk("stop_en_clear", 0, rd[C2_STOP_EN]);
		clr;
		$display("stop done");
		coll <= 1'b1;
		bus(1'b1, OFS_XFER_BUFFER, 32'h0000_00ff, 4'h1);
		poll(ST_BUS_COLL);
		chk("coll_flag", 1, rd[ST_BUS_COLL]);
		chk("coll_full", 0, rd[ST_BUF_FULL]);
		chk("coll_lines", 0, loe);
		coll <= 1'b0;
		repeat (6) @(posedge clk_i);
		bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
		chk("coll_stop_irq", 1, rd[ST_PORT_IRQ]);
		clr;
		tx(8'h3c, 1'b1, 0);
		bus(1'b1, OFS_XFER_BUFFER, 32'h0000_0081, 4'h1);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("reset_lines", 0, loe);
		bus(1'b0, OFS_PORT_STATUS, 32'h0000_0000, 4'hf);
		chk("reset_status", 0, rd);
		bus(1'b0, OFS_PORT_CONFIG, 32'h0000_0000, 4'hf);
		chk("reset_config", 0, rd);
		$display("reset done");
		wrap_up;
	end
endmodule
`default_nettype wire
